// file: shared/soc_defs.svh
// strap capture constants: offsets, field positions, reset values, timing
`ifndef SOC_DEFS_SVH
`define SOC_DEFS_SVH
// io port pair
`define SOC_INDEX_PORT 16'h0022
`define SOC_DATA_PORT 16'h0023
// register indices
`define SOC_IDX_STRAP_ONE 8'h4B
`define SOC_IDX_STRAP_TWO 8'h4C
`define SOC_IDX_HCLK_SYNTH 8'h5F
// memory data pin positions
`define SOC_PIN_BOOT_WIDTH 36
`define SOC_PIN_MULT_LO 14
`define SOC_PIN_MULT_HI 40
`define SOC_PIN_SYNTH_LO 24
`define SOC_PIN_HCLK_DIR 18
`define SOC_PIN_MCLK_EN 19
`define SOC_PIN_DOT_CLOCK_PIN_DIR 20
`define SOC_PIN_DESKEW_LO 45
`define SOC_PIN_DESKEW_HI 46
`define SOC_PIN_SERIAL_PORT_TWO 50
`define SOC_PIN_SERIAL_PORT_ONE 51
`define SOC_PIN_KBD 52
`define SOC_PIN_PARPORT 53
`define SOC_PIN_HSPEED_LO 2
`define SOC_PIN_HSPEED_HI 3
// field positions in strap register two
`define SOC_S2_PARPORT 7
`define SOC_S2_KBD 6
`define SOC_S2_DOT_CLOCK_PIN 4
`define SOC_S2_MCLK 3
`define SOC_S2_HCLK 2
`define SOC_S2_SERIAL_PORT_ONE 1
`define SOC_S2_SERIAL_PORT_TWO 0
// reset value of captured registers before capture
`define SOC_STRAP_RESET 8'h00
// cycles the pins are sampled after reset release
`define SOC_SETTLE_CYCLES 4'h3
`endif

// file: shared/soc_pkg.sv
// strap capture types
package soc_pkg;
  typedef enum logic [2:0] {
    SOC_ST_SETTLE = 3'b001,
    SOC_ST_LOAD = 3'b010,
    SOC_ST_RUN = 3'b100
  } soc_state_e;
  typedef enum logic [2:0] {
    SOC_MULT_X1 = 3'h1,
    SOC_MULT_X2 = 3'h2,
    SOC_MULT_RSV = 3'h4
  } soc_mult_e;
  typedef logic [7:0] soc_byte_t;
endpackage

// file: shared/soc_cap_if.sv
// carrier between capture sequencer and main strap module
`timescale 1ns/1ps
interface soc_cap_if;
  logic load;
  logic [63:0] pins;
  modport src(output load, output pins);
  modport dst(input load, input pins);
endinterface

// file: design/soc_capture_seq.sv
// synchronises memory data pins and pulses a load after reset release
`timescale 1ns/1ps
`include "soc_defs.svh"
module soc_capture_seq (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // board pins
  input wire logic [63:0] memory_data_pins,
  // to main module
  soc_cap_if.src cap
);
  import soc_pkg::*;
  typedef struct packed {
    logic [63:0] s1;
    logic [63:0] s2;
    logic [63:0] s3;
    logic [3:0] cnt;
    soc_state_e st;
    logic load;
  } soc_seq_s;
  soc_seq_s st_ff;
  soc_seq_s nxt_st_ff;
  always_comb begin
    nxt_st_ff = st_ff;
    nxt_st_ff.s1 = memory_data_pins;
    nxt_st_ff.s2 = st_ff.s1;
    nxt_st_ff.s3 = st_ff.s2;
    nxt_st_ff.load = 1'b0;
    unique case (st_ff.st)
      SOC_ST_SETTLE: begin
        // wait until the pipeline is full and stages two and three agree
        if (st_ff.cnt == `SOC_SETTLE_CYCLES) begin
          if (st_ff.s2 == st_ff.s3) begin
            nxt_st_ff.st = SOC_ST_LOAD;
          end
        end else begin
          nxt_st_ff.cnt = st_ff.cnt + 4'h1;
        end
      end
      SOC_ST_LOAD: begin
        nxt_st_ff.load = 1'b1;
        nxt_st_ff.st = SOC_ST_RUN;
      end
      SOC_ST_RUN: begin
        nxt_st_ff.st = SOC_ST_RUN;
      end
      default: begin
        nxt_st_ff.st = SOC_ST_SETTLE;
      end
    endcase
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{s1: 64'h0, s2: 64'h0, s3: 64'h0, cnt: 4'h0, st: SOC_ST_SETTLE,
                 load: 1'b0};
    end else begin
      st_ff <= nxt_st_ff;
    end
  end
  assign cap.load = st_ff.load;
  assign cap.pins = st_ff.s3;
endmodule

// file: design/soc_io_port.sv
// index/data io port decoder
`timescale 1ns/1ps
`include "soc_defs.svh"
module soc_io_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // io cycle
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  // decoded
  output logic [7:0] index_q,
  output logic data_sel
);
  import soc_pkg::*;
  typedef struct packed {
    logic [7:0] idx;
  } soc_io_s;
  soc_io_s st_ff;
  soc_io_s nxt_st_ff;
  always_comb begin
    nxt_st_ff = st_ff;
    if (io_wr && io_addr == `SOC_INDEX_PORT) begin
      nxt_st_ff.idx = io_wdata;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{idx: 8'h00};
    end else begin
      st_ff <= nxt_st_ff;
    end
  end
  assign index_q = st_ff.idx;
  assign data_sel = (io_addr == `SOC_DATA_PORT);
endmodule

// file: design/soc_strap_capture.sv
// strap option capture: three strap registers behind the index/data io pair
// Functional notes
// - at reset each strap register loads its memory data pin levels; code loads 00, then the pins after release once capture settles
// - registers reached via io index/data pair; host clock strap at index 5F
// - strap register one (4B) read only; bits 5..1 reserved
// - bits 7..6 of register one: clock multiplier, 01 x1, 11 x2, else reserved
// - bit 0 of register one: boot width, 0 eight bit, 1 sixteen bit
// - host clock strap register: bits 7..6 read zero, bits 2..0 reserved
// - host clock register bits 5..3 mirror synthesizer straps, drive synthesizer
// - speed straps low: 000 25, 001 50, 010 60, 011 66 MHz; else reserved
// - strap register two (4C) read only except writable bit 4
// - register two bit 7 enables parallel port
// - register two bit 6 enables keyboard controller; bit 5 reserved
// - register two bit 4: dot clock pin input or driven by synthesizer
// - register two bit 3: memory clock out pin tristated or driven
// - register two bit 2: host clock pin input or driven by synthesizer
// - register two bit 1 enables serial port one
// - register two bit 0 enables serial port two
// - deskew straps: 10 for 33..64 MHz host clock, 01 for 64..133 MHz
// - deskew strap values never appear in readable registers
`timescale 1ns/1ps
`include "soc_defs.svh"
module soc_strap_capture (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // strap pins
  input wire logic [63:0] memory_data_pins,
  // io port
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output soc_pkg::soc_byte_t io_rdata,
  // configuration outputs
  output soc_pkg::soc_mult_e cpu_clock_mult,
  output logic boot_width_16,
  output logic [2:0] host_synth_sel,
  output logic host_synth_valid,
  output logic parport_en,
  output logic kbd_en,
  output logic serial_port_one_en,
  output logic serial_port_two_en,
  output logic dot_clock_pin_oe,
  output logic memory_clock_out_pin_oe,
  output logic host_clock_pin_oe,
  output logic [1:0] deskew_sel,
  output logic deskew_valid
);
  import soc_pkg::*;
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    soc_byte_t one;
    soc_byte_t two;
    soc_byte_t hsyn;
    logic [1:0] deskew;
    logic [1:0] hspeed;
    soc_byte_t rdata;
    soc_mult_e mult;
    logic boot16;
    logic [2:0] syn;
    logic syn_ok;
    logic [6:0] en;
    logic [1:0] dsk;
    logic dsk_ok;
  } soc_cap_s;
  soc_cap_s st_ff;
  soc_cap_s nxt_st_ff;
  soc_cap_if cap ();
  logic [7:0] index_q;
  logic data_sel;
  // ************************************************************
  // submodules
  // ************************************************************
  soc_capture_seq u_seq (
    .core_clk(core_clk),
    .rst(rst),
    .memory_data_pins(memory_data_pins),
    .cap(cap)
  );
  soc_io_port u_io (
    .core_clk(core_clk),
    .rst(rst),
    .io_addr(io_addr),
    .io_wr(io_wr),
    .io_wdata(io_wdata),
    .index_q(index_q),
    .data_sel(data_sel)
  );
  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic soc_mult_e mult_decode(input logic [1:0] m);
    // m = {bit7 (pin 40), bit6 (pin 14)}
    if (m == 2'b01) begin
      mult_decode = SOC_MULT_X1;
    end else if (m == 2'b11) begin
      mult_decode = SOC_MULT_X2;
    end else begin
      mult_decode = SOC_MULT_RSV;
    end
  endfunction
  function automatic logic synth_ok(input logic [1:0] hs, input logic [2:0] s);
    synth_ok = (hs == 2'b00) && (s[2] == 1'b0);
  endfunction
  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [63:0] p;
    p = cap.pins;
    nxt_st_ff = st_ff;
    if (cap.load) begin
      nxt_st_ff.one = {p[`SOC_PIN_MULT_HI], p[`SOC_PIN_MULT_LO], 5'h00,
                       p[`SOC_PIN_BOOT_WIDTH]};
      nxt_st_ff.two = {p[`SOC_PIN_PARPORT], p[`SOC_PIN_KBD], 1'b0,
                       p[`SOC_PIN_DOT_CLOCK_PIN_DIR], p[`SOC_PIN_MCLK_EN],
                       p[`SOC_PIN_HCLK_DIR], p[`SOC_PIN_SERIAL_PORT_ONE],
                       p[`SOC_PIN_SERIAL_PORT_TWO]};
      nxt_st_ff.hsyn = {2'b00, p[`SOC_PIN_SYNTH_LO + 2], p[`SOC_PIN_SYNTH_LO + 1],
                        p[`SOC_PIN_SYNTH_LO], 3'b000};
      nxt_st_ff.deskew = {p[`SOC_PIN_DESKEW_LO], p[`SOC_PIN_DESKEW_HI]};
      nxt_st_ff.hspeed = {p[`SOC_PIN_HSPEED_HI], p[`SOC_PIN_HSPEED_LO]};
    end else if (io_wr && data_sel && index_q == `SOC_IDX_STRAP_TWO) begin
      // only the dot clock direction bit accepts writes
      nxt_st_ff.two[`SOC_S2_DOT_CLOCK_PIN] = io_wdata[`SOC_S2_DOT_CLOCK_PIN];
    end
    // other writes leave captured values alone
    nxt_st_ff.rdata = 8'h00;
    if (io_rd && data_sel) begin
      unique case (index_q)
        `SOC_IDX_STRAP_ONE: nxt_st_ff.rdata = st_ff.one;
        `SOC_IDX_STRAP_TWO: nxt_st_ff.rdata = st_ff.two;
        `SOC_IDX_HCLK_SYNTH: nxt_st_ff.rdata = st_ff.hsyn & 8'h3F;
        default: nxt_st_ff.rdata = 8'h00;
      endcase
    end
    nxt_st_ff.mult = mult_decode(st_ff.one[7:6]);
    nxt_st_ff.boot16 = st_ff.one[0];
    nxt_st_ff.syn = st_ff.hsyn[5:3];
    nxt_st_ff.syn_ok = synth_ok(st_ff.hspeed, st_ff.hsyn[5:3]);
    nxt_st_ff.en[6] = st_ff.two[`SOC_S2_PARPORT];
    nxt_st_ff.en[5] = st_ff.two[`SOC_S2_KBD];
    nxt_st_ff.en[4] = st_ff.two[`SOC_S2_DOT_CLOCK_PIN];
    nxt_st_ff.en[3] = st_ff.two[`SOC_S2_MCLK];
    nxt_st_ff.en[2] = st_ff.two[`SOC_S2_HCLK];
    nxt_st_ff.en[1] = st_ff.two[`SOC_S2_SERIAL_PORT_ONE];
    nxt_st_ff.en[0] = st_ff.two[`SOC_S2_SERIAL_PORT_TWO];
    nxt_st_ff.dsk = st_ff.deskew;
    nxt_st_ff.dsk_ok = (st_ff.deskew == 2'b10) || (st_ff.deskew == 2'b01);
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{one: `SOC_STRAP_RESET, two: `SOC_STRAP_RESET,
                 hsyn: `SOC_STRAP_RESET, deskew: 2'b00, hspeed: 2'b00,
                 rdata: 8'h00, mult: SOC_MULT_RSV, boot16: 1'b0, syn: 3'h0,
                 syn_ok: 1'b0, en: 7'h00, dsk: 2'b00, dsk_ok: 1'b0};
    end else begin
      st_ff <= nxt_st_ff;
    end
  end
  // ************************************************************
  // outputs
  // ************************************************************
  assign io_rdata = st_ff.rdata;
  assign cpu_clock_mult = st_ff.mult;
  assign boot_width_16 = st_ff.boot16;
  assign host_synth_sel = st_ff.syn;
  assign host_synth_valid = st_ff.syn_ok;
  assign parport_en = st_ff.en[6];
  assign kbd_en = st_ff.en[5];
  assign dot_clock_pin_oe = st_ff.en[4];
  assign memory_clock_out_pin_oe = st_ff.en[3];
  assign host_clock_pin_oe = st_ff.en[2];
  assign serial_port_one_en = st_ff.en[1];
  assign serial_port_two_en = st_ff.en[0];
  assign deskew_sel = st_ff.dsk;
  assign deskew_valid = st_ff.dsk_ok;
endmodule

// file: test/soc_board_straps.sv
// board pull resistors on the memory data pins
`timescale 1ns/1ps
module soc_board_straps (
  // chosen pull of each pin, 1 up and 0 down
  input wire logic [63:0] pull_up_mask,
  // pins seen by the device
  output logic [63:0] memory_data_pins
);
  // every strap pin has a resistor, so none floats
  assign memory_data_pins = pull_up_mask;
endmodule

// file: test/soc_strap_checker.sv
// concurrent checks on the strap capture ports
`timescale 1ns/1ps
module soc_strap_checker
  import soc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins and io port
  input wire logic [63:0] memory_data_pins,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  input wire soc_byte_t io_rdata,
  // configuration
  input wire soc_mult_e cpu_clock_mult,
  input wire logic boot_width_16,
  input wire logic [2:0] host_synth_sel,
  input wire logic host_synth_valid,
  input wire logic parport_en,
  input wire logic kbd_en,
  input wire logic serial_port_one_en,
  input wire logic serial_port_two_en,
  input wire logic dot_clock_pin_oe,
  input wire logic memory_clock_out_pin_oe,
  input wire logic host_clock_pin_oe,
  input wire logic [1:0] deskew_sel,
  input wire logic deskew_valid
);
  // ****
  // helpers: shadow index and settle age
  // ****
  logic [7:0] idx_ff;
  logic [3:0] age_ff;
  logic rd_s;
  logic wr_s;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx_ff <= 8'h00;
      age_ff <= 4'h0;
    end else begin
      if (io_wr && io_addr == 16'h0022) begin
        idx_ff <= io_wdata;
      end
      if (age_ff != 4'hF) begin
        age_ff <= age_ff + 4'h1;
      end
    end
  end
  // data port accesses once the capture has settled
  assign rd_s = io_rd && io_addr == 16'h0023 && age_ff == 4'hF;
  assign wr_s = io_wr && io_addr == 16'h0023 && age_ff == 4'hF;
  a_rdata_idle: assert property (!io_rd |=> io_rdata == 8'h00)
    else $error("read data not zero without a read");
  a_one_rsv_boot: assert property (rd_s && idx_ff == 8'h4B |=>
    io_rdata[5:1] == 5'h00 && boot_width_16 == io_rdata[0])
    else $error("strap one reserved bits or boot width wrong");
  a_mult_decode: assert property (rd_s && idx_ff == 8'h4B |=> cpu_clock_mult ==
    (io_rdata[7:6] == 2'b01 ? SOC_MULT_X1 : io_rdata[7:6] == 2'b11 ? SOC_MULT_X2 : SOC_MULT_RSV))
    else $error("multiplier does not follow strap one");
  a_synth_mirror: assert property (rd_s && idx_ff == 8'h5F |=> io_rdata[7:6] == 2'h0 &&
    io_rdata[2:0] == 3'h0 && io_rdata[5:3] == host_synth_sel)
    else $error("host clock strap register wrong");
  a_synth_valid: assert property (age_ff == 4'hF |-> host_synth_valid ==
    (memory_data_pins[3:2] == 2'b00 && !host_synth_sel[2]))
    else $error("synthesizer valid wrong");
  a_two_fields: assert property (rd_s && idx_ff == 8'h4C |=>
    io_rdata[5] == 1'b0 && {parport_en, kbd_en} == io_rdata[7:6] &&
    {dot_clock_pin_oe, memory_clock_out_pin_oe, host_clock_pin_oe} == io_rdata[4:2] &&
    {serial_port_one_en, serial_port_two_en} == io_rdata[1:0])
    else $error("strap two outputs disagree with register");
  a_deskew_pins: assert property (age_ff == 4'hF |-> deskew_sel ==
    {memory_data_pins[45], memory_data_pins[46]} && deskew_valid == ^deskew_sel)
    else $error("deskew capture wrong");
  a_ro_ignored: assert property (wr_s && idx_ff == 8'h4B |=> ##1
    $stable(boot_width_16) && $stable(cpu_clock_mult))
    else $error("write changed strap one");
  c_read_two: cover property (rd_s && idx_ff == 8'h4C);
  c_write_two: cover property (wr_s && idx_ff == 8'h4C);
  c_deskew_ok: cover property (age_ff == 4'hF && deskew_valid);
endmodule
bind soc_strap_capture soc_strap_checker i_soc_strap_checker (.*);

// file: test/testbench.sv
// self-checking bench for the strap capture block
`timescale 1ns/1ps
module testbench;
  import soc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [63:0] pulls = 64'h0;
  logic [63:0] memory_data_pins;
  logic [15:0] io_addr = 16'h0000;
  logic io_rd = 1'b0;
  logic io_wr = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  soc_byte_t io_rdata;
  soc_mult_e cpu_clock_mult;
  logic [2:0] host_synth_sel;
  logic [1:0] deskew_sel;
  logic boot_width_16, host_synth_valid, parport_en, kbd_en, serial_port_one_en;
  logic serial_port_two_en, dot_clock_pin_oe, memory_clock_out_pin_oe, host_clock_pin_oe;
  logic deskew_valid;
  logic [17:0] outs;
  logic [63:0] p;
  logic [7:0] e1, e2, e5;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [63:0] pats [5] = '{64'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0014_2010_0108_4000,
    64'h0028_4100_0314_0004, 64'h0000_0100_0200_4000};
  always #12.5 core_clk = ~core_clk;
  soc_board_straps i_soc_board_straps (.pull_up_mask(pulls), .memory_data_pins(memory_data_pins));
  soc_strap_capture i_soc_strap_capture (.*);
  assign outs = {cpu_clock_mult, boot_width_16, host_synth_sel, host_synth_valid, parport_en,
    kbd_en, serial_port_one_en, serial_port_two_en, dot_clock_pin_oe, memory_clock_out_pin_oe,
    host_clock_pin_oe, deskew_sel, deskew_valid};
  // ****
  // tasks
  // ****
  function automatic logic [17:0] exp_outs(input logic [63:0] q);
    logic [2:0] m;
    m = (!q[40] && q[14]) ? 3'h1 : (q[40] && q[14]) ? 3'h2 : 3'h4;
    return {m, q[36], q[26:24], q[3:2] == 2'b00 && !q[26], q[53], q[52], q[51], q[50],
      q[20], q[19], q[18], q[45], q[46], q[45] ^ q[46]};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
  endtask
  task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
    io_write(16'h0022, idx);
    io_write(16'h0023, d);
  endtask
  task automatic reg_read(input logic [7:0] idx, input logic [7:0] exp);
    io_write(16'h0022, idx);
    @(posedge core_clk);
    io_addr <= 16'h0023;
    io_rd <= 1'b1;
    @(posedge core_clk);
    io_rd <= 1'b0;
    #1 check({10'h0, io_rdata}, {10'h0, exp});
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ****
  // one reset and capture per strap pattern
  // ****
  initial begin
    for (int i = 0; i < 5; i++) begin
      p = pats[i];
      @(posedge core_clk);
      rst <= 1'b1;
      pulls <= p;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      repeat (20) @(posedge core_clk);
      e1 = {p[40], p[14], 5'h00, p[36]};
      e2 = {p[53:52], 1'b0, p[20:18], p[51:50]};
      e5 = {2'h0, p[26:24], 3'h0};
      check(outs, exp_outs(p));
      reg_read(8'h4B, e1);
      reg_read(8'h5F, e5);
      reg_read(8'h4C, e2);
      reg_write(8'h4B, ~e1);
      reg_write(8'h5F, ~e5);
      reg_write(8'h4C, ~e2);
      reg_read(8'h4B, e1);
      reg_read(8'h5F, e5);
      reg_read(8'h4C, e2 ^ 8'h10);
      reg_read(8'h4D, 8'h00);
      check(outs, exp_outs(p) ^ 18'h00020);
    end
    end_of_test();
  end
endmodule
